//--- dv/oms_board.sv
/* Board side: mode straps and the outside line pulse source.
   Assumes the bench changes straps only while reset is held. */
`timescale 1ns/1ps
module oms_board (
   input wire oms_pkg::oms_strap_t strap,
   input wire logic fire,
   output logic master_slave_select,
   output logic mem_mode_sel1,
   output logic mem_mode_sel0,
   output logic sync_drv
);
   // ==========================================
   // Straps, static from before reset release
   assign master_slave_select = strap.master;
   assign mem_mode_sel1 = strap.sel1;
   assign mem_mode_sel0 = strap.sel0;
   // Only a slave is handed a line pulse from outside
   assign sync_drv = fire & ~strap.master;
endmodule

//--- dv/operating_mode_select_bench.sv
/* Self-checking bench of oms_top over every strap setting.
   Assumes oms_board drives the straps and the slave line pulse. */
`timescale 1ns/1ps
module operating_mode_select_bench;
   // ==========================================
   // Signals
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [31:0] s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
   // Answers are always taken at once
   logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic master_slave_select, mem_mode_sel0, mem_mode_sel1, sync_drv;
   logic dc_test_sel0 = 1'h0, dc_test_sel1 = 1'h0, fire = 1'h0;
   logic line_sync_i, line_sync_o, line_sync_oe, master_clock_out;
   logic master_clock_out_oe, image_clk_en, line_start, test_data_mode;
   logic [15:0] gpo_o, gpo_oe;
   oms_pkg::oms_mode_t mode;
   oms_pkg::oms_memcfg_t mem_cfg;
   oms_pkg::oms_strap_t strap = 3'h0;
   int err_total = 0, n_checks = 0, seed = 22885;
   int mt_t[4] = '{16, 8, 2, 2};
   int ns_t[4] = '{1, 2, 4, 0};
   int oe_t[4] = '{16'hffff, 16'h0007, 16'h0000, 16'h0000};
   int gc_t[4] = '{16, 3, 0, 0};
   // Device drive wins on the pin when enabled
   assign line_sync_i = line_sync_oe ? line_sync_o : sync_drv;

   initial forever #5 aclk = ~aclk;

   oms_board oms_board_i (.strap, .fire, .master_slave_select,
      .mem_mode_sel1, .mem_mode_sel0, .sync_drv);
   oms_top oms_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .master_slave_select,
      .mem_mode_sel0, .mem_mode_sel1, .dc_test_sel0, .dc_test_sel1,
      .line_sync_i, .line_sync_o, .line_sync_oe, .master_clock_out,
      .master_clock_out_oe, .gpo_o, .gpo_oe, .image_clk_en, .line_start,
      .test_data_mode, .mode, .mem_cfg);

   // ==========================================
   // Tasks
   task automatic close_out;
      if (err_total == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         err_total++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic to(input int n);
      if (n >= 1000)
      begin
         err_total++;
         close_out;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] er = 2'h0);
      int n;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      for (n = 0; n < 1000; n++) @(posedge aclk) if (s_axi_awready) break;
      to(n);
      s_axi_awvalid <= 1'h0;
      s_axi_wvalid <= 1'h0;
      for (n = 0; n < 1000; n++) @(posedge aclk) if (s_axi_bvalid) break;
      to(n);
      chk("bresp", er, s_axi_bresp);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'h1;
      for (n = 0; n < 1000; n++) @(posedge aclk) if (s_axi_arready) break;
      to(n);
      s_axi_arvalid <= 1'h0;
      for (n = 0; n < 1000; n++) @(posedge aclk) if (s_axi_rvalid) break;
      to(n);
      d = s_axi_rdata;
      r = s_axi_rresp;
   endtask

   function automatic bit pick(input bit w);
      return (w ? line_sync_o : image_clk_en) === 1'h1;
   endfunction

   // Cycles between two pulses of image clock (w=0) or line sync (w=1)
   task automatic gap(input bit w, output int n);
      int k;
      for (k = 0; k < 1000; k++) @(posedge aclk) if (pick(w)) break;
      to(k);
      for (n = 1; n < 1000; n++) @(posedge aclk) if (pick(w)) break;
      to(n);
   endtask

   // ==========================================
   // Main sequence
   initial
   begin
      int c, n, mt, em;
      logic [31:0] r, d;
      logic [1:0] e, sv;
      logic ms, p;
      for (c = 0; c < 8; c++)
      begin
         ms = c[2];
         sv = c[1:0];
         mt = mt_t[sv];
         em = sv == 2'h3 ? (ms ? 4 : 3) : sv;
         aresetn <= 1'h0;
         strap <= oms_pkg::oms_strap_t'(c[2:0]);
         repeat (4) @(posedge aclk);
         aresetn <= 1'h1;
         @(posedge aclk);
         // Short line set before the line counter starts
         wr(8'h04, 32'h3);
         repeat (12) @(posedge aclk);
         chk("mode", em, mode);
         chk("test_mode", !ms && sv == 2'h3, test_data_mode);
         rd(8'h0c, d, e);
         chk("status_mode", em, d[20:18]);
         if (c == 7)
            for (n = 0; n < 4; n++)
            begin
               dc_test_sel0 <= n[0];
               dc_test_sel1 <= n[1];
               repeat (6) @(posedge aclk);
               chk("dc_oe", {16{n[0]}}, gpo_oe);
               chk("dc_sync_oe", n[0], line_sync_oe);
               chk("dc_mclk_oe", n[0], master_clock_out_oe);
               if (n[0])
               begin
                  chk("dc_lvl", {16{n[1]}}, gpo_o);
                  chk("dc_sync_lvl", n[1], line_sync_o);
                  chk("dc_mclk", n[1], master_clock_out);
               end
            end
         else
         begin
            gap(1'h0, n);
            chk("img_gap", mt, n);
            chk("mult", mt, mem_cfg.mult);
            chk("gpo_oe", oe_t[sv], gpo_oe);
            chk("gpo_cnt", gc_t[sv], mem_cfg.gpo_count);
            chk("over_rate", sv != 2'h3, mem_cfg.over_rate);
            chk("n_sram", ns_t[sv], mem_cfg.n_sram);
            chk("fifo", sv == 2'h2, mem_cfg.fifo_5k);
            chk("small_ram", 1'h0, mem_cfg.sram_256k);
            wr(8'h00, 32'h3);
            repeat (4) @(posedge aclk);
            chk("n_sram_enl", sv == 2'h1 ? 3 : ns_t[sv],
               mem_cfg.n_sram);
            chk("big_ram", sv == 2'h0, mem_cfg.sram_256k);
            r = $random(seed);
            wr(8'h08, r);
            rd(8'h08, d, e);
            chk("gpo_rd", r[15:0], d);
            chk("gpo_o", r[15:0], gpo_o);
            wr(8'h10, r[25:16]);
            wr(8'h14, r[31:24]);
            wr(8'h10, r[25:16]);
            rd(8'h14, d, e);
            chk("shd", r[31:24], d);
            rd(8'h18, d, e);
            chk("bad_resp", 2'h2, e);
            wr(8'h18, r, 2'h2);
            if (ms)
            begin
               gap(1'h1, n);
               chk("line_gap", 3 * mt, n);
               chk("sync_oe", 1'h1, line_sync_oe);
               wr(8'h00, 32'h0);
               repeat (4) @(posedge aclk);
               chk("sync_oe_off", 1'h0, line_sync_oe);
               chk("mclk_oe", 1'h1, master_clock_out_oe);
               p = master_clock_out;
               @(posedge aclk);
               chk("mclk", !p, master_clock_out);
            end
            else
            begin
               chk("slave_oe", 1'h0, line_sync_oe);
               fire <= 1'h1;
               for (n = 1; n < 1000; n++) @(posedge aclk)
                  if (line_start) break;
               to(n);
               chk("slave_lag", 3, n);
               fire <= 1'h0;
            end
         end
      end
      close_out;
   end
endmodule

//--- hw/oms_pkg.sv
/*
 * Constants, types and register map of the operating-mode select block.
 * Assumes a 100 MHz master clock and a 32-bit AXI4-Lite register bus.
 */
package oms_pkg;

   // ==========================================================
   // Clock and image-clock ratios
   localparam int CLK_MHZ = 100;
   localparam logic [4:0] MULT_LOW = 5'h10;
   localparam logic [4:0] MULT_MED = 5'h08;
   localparam logic [4:0] MULT_HIGH = 5'h02;
   localparam logic [4:0] MULT_TEST = 5'h02;
   localparam int FMAX_LOW_KHZ = 1000;
   localparam int FMAX_MED_KHZ = 3000;
   localparam int FMAX_HIGH_KHZ = 6000;
   localparam bit OVER_LOW = (CLK_MHZ * 1000 / 16) > FMAX_LOW_KHZ;
   localparam bit OVER_MED = (CLK_MHZ * 1000 / 8) > FMAX_MED_KHZ;
   localparam bit OVER_HIGH = (CLK_MHZ * 1000 / 2) > FMAX_HIGH_KHZ;
   localparam logic [1:0] STRAP_SETTLE = 2'h3;

   // ==========================================================
   // Register map (byte addresses)
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_LINE_LEN = 8'h04;
   localparam logic [7:0] ADDR_GPO = 8'h08;
   localparam logic [7:0] ADDR_STATUS = 8'h0c;
   localparam logic [7:0] ADDR_SHD_ADDR = 8'h10;
   localparam logic [7:0] ADDR_SHD_DATA = 8'h14;
   localparam int CTRL_SYNC_SEL = 0;
   localparam int CTRL_ENLARGE = 1;
   localparam int CTRL_BLACK_SHD = 2;
   localparam logic [2:0] CTRL_RESET = 3'h1;
   localparam logic [15:0] LINE_LEN_RESET = 16'h0800;
   localparam logic [15:0] GPO_RESET = 16'h0000;
   localparam logic [15:0] SMALL_RAM_MAX_PIX = 16'h0800;
   localparam logic [15:0] GPO_LOW_MASK = 16'hffff;
   localparam logic [15:0] GPO_MED_MASK = 16'h0007;
   localparam logic [4:0] GPO_LOW_COUNT = 5'h10;
   localparam logic [4:0] GPO_MED_COUNT = 5'h03;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ==========================================================
   // Types
   typedef enum logic [2:0] {
      MODE_LOW, MODE_MED, MODE_HIGH, MODE_TEST, MODE_DC_OUTPUT_TEST_MODE
   } oms_mode_t;

   typedef struct packed {
      logic master;
      logic sel1;
      logic sel0;
   } oms_strap_t;

   typedef struct packed {
      logic [2:0] n_sram;
      logic sram_256k;
      logic fifo_5k;
      logic [4:0] gpo_count;
      logic [4:0] mult;
      logic over_rate;
   } oms_memcfg_t;

   typedef struct packed {
      logic [2:0] mode;
      logic strap_valid;
      logic sync_out_active;
      oms_memcfg_t cfg;
   } oms_status_t;

endpackage

//--- hw/oms_shd_ram.sv
/*
 * Shading memory: one write port, one read port, registered read data.
 * Assumes the reader takes data one cycle after presenting the address.
 */
`timescale 1ns/1ps
module oms_shd_ram #(
   parameter int AW = 10,
   parameter int DW = 8
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];
   logic [DW-1:0] rdata_q;

   if (AW < 1 || AW > 16 || DW < 1 || DW > 32)
   begin : g_chk
      $error("oms_shd_ram: AW must be 1..16 and DW 1..32");
   end

   always_ff @(posedge aclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
      rdata_q <= mem[raddr];
   end

   assign rdata = rdata_q;

endmodule

//--- hw/oms_sync2.sv
/*
 * Two-flop level synchroniser for asynchronous pins.
 * Assumes each bit is an independent static or slow level.
 */
`timescale 1ns/1ps
module oms_sync2 #(
   parameter int W = 1
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   if (W < 1)
   begin : g_chk
      $error("oms_sync2: W must be at least 1");
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= din;
         sync_q <= meta_q;
      end
   end

   assign dout = sync_q;

endmodule

//--- hw/oms_top.sv
/*
 * Operating-mode select: strap decode, image clock, line sync, DC test
 * pin control, spare port control and shading memory access over
 * AXI4-Lite.
 * Assumes straps are static from before reset release and that the
 * master clock runs at the multiple of the image clock that the mode
 * needs.
 */
// Functional notes
// - Master generates line sync and drives it when sync select is set
// - Slave takes line timing from external sync
// - Mode straps set image clock ratio 16/8/2
// - Slave with both mode straps high: test
// - Master with both mode straps high: DC test
// - DC test floats, drives low or high
// - Low mode uses one 256K or 64K RAM
// - Medium mode uses three or two SRAMs
// - High mode uses four SRAMs plus FIFO
// - Shading memory readable and writable in all modes
// - Spare output pins: sixteen low, three medium
// - Sync pin input in slave, output if selected
// - Master without sync select outputs master clock
`timescale 1ns/1ps
module oms_top #(
   parameter int SHD_AW = 10
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic master_slave_select,
   input wire logic mem_mode_sel0,
   input wire logic mem_mode_sel1,
   input wire logic dc_test_sel0,
   input wire logic dc_test_sel1,
   input wire logic line_sync_i,
   output logic line_sync_o,
   output logic line_sync_oe,
   output logic master_clock_out,
   output logic master_clock_out_oe,
   output logic [15:0] gpo_o,
   output logic [15:0] gpo_oe,
   output logic image_clk_en,
   output logic line_start,
   output logic test_data_mode,
   output oms_pkg::oms_mode_t mode,
   output oms_pkg::oms_memcfg_t mem_cfg
);

   if (SHD_AW < 1 || SHD_AW > 16)
   begin : g_chk
      $error("oms_top: SHD_AW must be 1..16");
   end

   // ==========================================================
   // Pin synchronisers and strap capture
   logic [5:0] pins_s;
   oms_pkg::oms_strap_t strap_q;
   logic strap_valid_q;
   logic [1:0] settle_q;
   logic dsel0;
   logic dsel1;
   logic ls_in_s;

   oms_sync2 #(.W(6)) u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .din({master_slave_select, mem_mode_sel1, mem_mode_sel0,
            dc_test_sel1, dc_test_sel0, line_sync_i}),
      .dout(pins_s)
   );

   assign dsel1 = pins_s[2];
   assign dsel0 = pins_s[1];
   assign ls_in_s = pins_s[0];

   // Straps are caught once, after the synchronisers have filled;
   // later changes are ignored on purpose
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         settle_q <= 2'h0;
         strap_valid_q <= 1'b0;
         strap_q <= '0;
      end
      else if (!strap_valid_q)
      begin
         settle_q <= settle_q + 2'h1;
         if (settle_q == oms_pkg::STRAP_SETTLE)
         begin
            strap_valid_q <= 1'b1;
            strap_q <= pins_s[5:3];
         end
      end
   end

   // ==========================================================
   // Mode decode
   oms_pkg::oms_mode_t mode_d;
   oms_pkg::oms_mode_t mode_q;
   wire both_hi = strap_q.sel1 & strap_q.sel0;
   wire is_master = strap_valid_q & strap_q.master;
   wire is_slave = strap_valid_q & ~strap_q.master;

   assign mode_d = !strap_q.sel1 && !strap_q.sel0 ? oms_pkg::MODE_LOW :
                   !strap_q.sel1 ? oms_pkg::MODE_MED :
                   !both_hi ? oms_pkg::MODE_HIGH :
                   strap_q.master ? oms_pkg::MODE_DC_OUTPUT_TEST_MODE :
                   oms_pkg::MODE_TEST;

   wire dct = strap_valid_q && mode_q == oms_pkg::MODE_DC_OUTPUT_TEST_MODE;

   // ==========================================================
   // Register file state
   logic [2:0] ctrl_q;
   logic [15:0] line_len_q;
   logic [15:0] gpo_reg_q;
   logic [SHD_AW-1:0] shd_addr_q;
   wire sync_sel = ctrl_q[oms_pkg::CTRL_SYNC_SEL];
   wire enlarge = ctrl_q[oms_pkg::CTRL_ENLARGE];
   wire black_shd = ctrl_q[oms_pkg::CTRL_BLACK_SHD];

   // ==========================================================
   // Memory configuration
   oms_pkg::oms_memcfg_t cfg_d;
   oms_pkg::oms_memcfg_t cfg_q;
   wire small_ok = !enlarge && !black_shd &&
                   line_len_q <= oms_pkg::SMALL_RAM_MAX_PIX;

   always_comb
   begin
      cfg_d = '0;
      case (mode_q)
         oms_pkg::MODE_LOW:
         begin
            cfg_d.n_sram = 3'h1;
            cfg_d.sram_256k = !small_ok;
            cfg_d.gpo_count = oms_pkg::GPO_LOW_COUNT;
            cfg_d.mult = oms_pkg::MULT_LOW;
            cfg_d.over_rate = oms_pkg::OVER_LOW;
         end
         oms_pkg::MODE_MED:
         begin
            cfg_d.n_sram = (enlarge || black_shd) ? 3'h3 : 3'h2;
            cfg_d.gpo_count = oms_pkg::GPO_MED_COUNT;
            cfg_d.mult = oms_pkg::MULT_MED;
            cfg_d.over_rate = oms_pkg::OVER_MED;
         end
         oms_pkg::MODE_HIGH:
         begin
            cfg_d.n_sram = 3'h4;
            cfg_d.fifo_5k = 1'b1;
            cfg_d.mult = oms_pkg::MULT_HIGH;
            cfg_d.over_rate = oms_pkg::OVER_HIGH;
         end
         oms_pkg::MODE_TEST:
         begin
            cfg_d.mult = oms_pkg::MULT_TEST;
         end
         default:
         begin
            cfg_d.mult = oms_pkg::MULT_HIGH;
         end
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         mode_q <= oms_pkg::MODE_LOW;
         cfg_q <= '0;
      end
      else
      begin
         mode_q <= mode_d;
         cfg_q <= cfg_d;
      end
   end

   // ==========================================================
   // Image clock enable and line timing
   logic [4:0] div_q;
   logic [15:0] line_cnt_q;
   logic ls_prev_q;
   logic line_sync_q;
   logic mclk_q;
   logic [15:0] gpo_q;
   wire [15:0] len_last = (line_len_q == 16'h0) ? 16'h0 :
                          line_len_q - 16'h1;
   wire image_signal_clock_en = strap_valid_q && div_q == cfg_q.mult - 5'h1;
   wire master_tick = is_master && image_signal_clock_en && line_cnt_q >= len_last;
   wire ls_rise = ls_in_s & ~ls_prev_q;
   wire slave_tick = is_slave && ls_rise;
   wire [15:0] gpo_mask = mode_q == oms_pkg::MODE_LOW ?
                          oms_pkg::GPO_LOW_MASK :
                          mode_q == oms_pkg::MODE_MED ?
                          oms_pkg::GPO_MED_MASK : 16'h0000;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || image_signal_clock_en || !strap_valid_q)
      begin
         div_q <= 5'h0;
      end
      else
      begin
         div_q <= div_q + 5'h1;
      end
   end

   // Slave lines restart the count so both ends stay aligned
   always_ff @(posedge aclk)
   begin
      if (!aresetn || master_tick || slave_tick)
      begin
         line_cnt_q <= 16'h0;
      end
      else if (image_signal_clock_en)
      begin
         line_cnt_q <= line_cnt_q + 16'h1;
      end
   end

   // Pin data come from flops; DC test forces every level
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ls_prev_q <= 1'b0;
         line_sync_q <= 1'b0;
         mclk_q <= 1'b0;
         gpo_q <= 16'h0000;
      end
      else
      begin
         ls_prev_q <= ls_in_s;
         line_sync_q <= dct ? dsel1 : master_tick;
         mclk_q <= dct ? dsel1 : ~mclk_q;
         gpo_q <= dct ? {16{dsel1}} : gpo_reg_q;
      end
   end

   // A flop cannot forward aclk itself; the clock out is aclk / 2
   assign line_sync_o = line_sync_q;
   assign master_clock_out = mclk_q;
   assign gpo_o = gpo_q;
   assign line_sync_oe = dct ? dsel0 : is_master & sync_sel;
   assign master_clock_out_oe = dct ? dsel0 : is_master & ~sync_sel;
   assign gpo_oe = dct ? {16{dsel0}} :
                   (strap_valid_q ? gpo_mask : 16'h0000);
   assign image_clk_en = image_signal_clock_en;
   assign line_start = master_tick | slave_tick;
   assign test_data_mode = strap_valid_q && mode_q == oms_pkg::MODE_TEST;
   assign mode = mode_q;
   assign mem_cfg = cfg_q;

   // ==========================================================
   // AXI4-Lite slave
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic rpend_q;
   logic [7:0] raddr_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic [7:0] shd_rd;
   oms_pkg::oms_status_t status;

   wire wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
   wire rd_go = s_axi_arvalid && !rvalid_q && !rpend_q;
   wire [7:0] wa = s_axi_awaddr;
   wire wa_ok = wa == oms_pkg::ADDR_CTRL || wa == oms_pkg::ADDR_LINE_LEN ||
                wa == oms_pkg::ADDR_GPO || wa == oms_pkg::ADDR_STATUS ||
                wa == oms_pkg::ADDR_SHD_ADDR || wa == oms_pkg::ADDR_SHD_DATA;
   wire shd_we = wr_go && wa == oms_pkg::ADDR_SHD_DATA && s_axi_wstrb[0];
   wire shd_rd_go = rd_go && s_axi_araddr == oms_pkg::ADDR_SHD_DATA;
   wire [SHD_AW-1:0] shd_wval = s_axi_wdata[SHD_AW-1:0];

   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;

   oms_shd_ram #(.AW(SHD_AW), .DW(8)) u_shd (
      .aclk(aclk),
      .we(shd_we),
      .waddr(shd_addr_q),
      .wdata(s_axi_wdata[7:0]),
      .raddr(shd_addr_q),
      .rdata(shd_rd)
   );

   assign status = '{mode: mode_q, strap_valid: strap_valid_q,
                     sync_out_active: line_sync_oe, cfg: cfg_q};

   wire [31:0] rd_mux =
      raddr_q == oms_pkg::ADDR_CTRL ? {29'h0, ctrl_q} :
      raddr_q == oms_pkg::ADDR_LINE_LEN ? {16'h0, line_len_q} :
      raddr_q == oms_pkg::ADDR_GPO ? {16'h0, gpo_reg_q} :
      raddr_q == oms_pkg::ADDR_STATUS ? 32'(status) :
      raddr_q == oms_pkg::ADDR_SHD_ADDR ? 32'(shd_addr_q) :
      raddr_q == oms_pkg::ADDR_SHD_DATA ? {24'h0, shd_rd} : 32'h0;
   wire ra_ok = raddr_q <= oms_pkg::ADDR_SHD_DATA && raddr_q[1:0] == 2'h0;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= oms_pkg::CTRL_RESET;
         line_len_q <= oms_pkg::LINE_LEN_RESET;
         gpo_reg_q <= oms_pkg::GPO_RESET;
      end
      else if (wr_go && s_axi_wstrb[0])
      begin
         if (wa == oms_pkg::ADDR_CTRL)
            ctrl_q <= s_axi_wdata[2:0];
         if (wa == oms_pkg::ADDR_LINE_LEN)
            line_len_q[7:0] <= s_axi_wdata[7:0];
         if (wa == oms_pkg::ADDR_GPO)
            gpo_reg_q[7:0] <= s_axi_wdata[7:0];
      end
      if (aresetn && wr_go && s_axi_wstrb[1])
      begin
         if (wa == oms_pkg::ADDR_LINE_LEN)
            line_len_q[15:8] <= s_axi_wdata[15:8];
         if (wa == oms_pkg::ADDR_GPO)
            gpo_reg_q[15:8] <= s_axi_wdata[15:8];
      end
   end

   // Data port walks the shading memory, so bulk loads need no
   // address write per byte
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         shd_addr_q <= '0;
      else if (wr_go && wa == oms_pkg::ADDR_SHD_ADDR && s_axi_wstrb[0])
         shd_addr_q <= shd_wval;
      else if (shd_we || shd_rd_go)
         shd_addr_q <= shd_addr_q + 1'b1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= oms_pkg::RESP_OKAY;
         rvalid_q <= 1'b0;
         rpend_q <= 1'b0;
         raddr_q <= 8'h00;
         rdata_q <= 32'h0;
         rresp_q <= oms_pkg::RESP_OKAY;
      end
      else
      begin
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            bresp_q <= wa_ok ? oms_pkg::RESP_OKAY : oms_pkg::RESP_SLVERR;
         end
         else if (s_axi_bready)
            bvalid_q <= 1'b0;
         rpend_q <= rd_go;
         if (rd_go)
            raddr_q <= s_axi_araddr;
         if (rpend_q)
         begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= ra_ok ? oms_pkg::RESP_OKAY : oms_pkg::RESP_SLVERR;
         end
         else if (s_axi_rready)
            rvalid_q <= 1'b0;
      end
   end

   // ==========================================================
   // Checks
   property p_ms_drive;
      @(posedge aclk) disable iff (!aresetn)
      is_master && sync_sel && !dct && master_tick |->
         line_sync_oe ##1 line_sync_o;
   endproperty
   a_ms_drive: assert property (p_ms_drive)
      else $error("master line sync not driven");

   property p_slave_in;
      @(posedge aclk) disable iff (!aresetn)
      is_slave && !dct && ls_rise |-> line_start && !line_sync_oe;
   endproperty
   a_slave_in: assert property (p_slave_in)
      else $error("slave did not follow external sync");

   // Cycles since the last image clock pulse, saturating; a long run of
   // idle cycles is cheaper to count than to unroll
   logic [4:0] ck_gap_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || image_signal_clock_en)
         ck_gap_q <= 5'h00;
      else if (ck_gap_q != 5'h1f)
         ck_gap_q <= ck_gap_q + 5'h01;
   end

   property p_div_low;
      @(posedge aclk) disable iff (!aresetn)
      mode_q == oms_pkg::MODE_LOW && image_signal_clock_en |->
         ##16 image_signal_clock_en && ck_gap_q == 5'h0f;
   endproperty
   a_div_low: assert property (p_div_low)
      else $error("low mode image clock not master / 16");

   property p_div_test;
      @(posedge aclk) disable iff (!aresetn)
      test_data_mode && image_signal_clock_en |=> !image_signal_clock_en ##1 image_signal_clock_en;
   endproperty
   a_div_test: assert property (p_div_test)
      else $error("test mode image clock not master / 2");

   property p_dct_float;
      @(posedge aclk) disable iff (!aresetn)
      dct && !dsel0 |-> gpo_oe == 16'h0000 && !line_sync_oe &&
         !master_clock_out_oe;
   endproperty
   a_dct_float: assert property (p_dct_float)
      else $error("DC test float left a pin driven");

   property p_dct_level;
      @(posedge aclk) disable iff (!aresetn)
      dct && dsel0 && $stable(dsel1) |=>
         gpo_o == {16{$past(dsel1)}} && line_sync_o == $past(dsel1);
   endproperty
   a_dct_level: assert property (p_dct_level)
      else $error("DC test level wrong");

   property p_cfg;
      @(posedge aclk) disable iff (!aresetn)
      mode_q == oms_pkg::MODE_HIGH |=> cfg_q.n_sram == 3'h4 &&
         cfg_q.fifo_5k;
   endproperty
   a_cfg: assert property (p_cfg)
      else $error("high mode memory configuration wrong");

   property p_cfg_med;
      @(posedge aclk) disable iff (!aresetn)
      mode_q == oms_pkg::MODE_MED |=>
         cfg_q.n_sram == ($past(enlarge || black_shd) ? 3'h3 : 3'h2);
   endproperty
   a_cfg_med: assert property (p_cfg_med)
      else $error("medium mode SRAM count wrong");

   property p_gpo;
      @(posedge aclk) disable iff (!aresetn)
      strap_valid_q && !dct && mode_q == oms_pkg::MODE_MED |->
         gpo_oe == 16'h0007;
   endproperty
   a_gpo: assert property (p_gpo)
      else $error("medium mode spare ports wrong");

   property p_mclk;
      @(posedge aclk) disable iff (!aresetn)
      is_master && !sync_sel && !dct |-> master_clock_out_oe &&
         !line_sync_oe;
   endproperty
   a_mclk: assert property (p_mclk)
      else $error("master clock out not enabled");

   property p_shd_rd;
      @(posedge aclk) disable iff (!aresetn)
      shd_rd_go |=> ##1 rvalid_q;
   endproperty
   a_shd_rd: assert property (p_shd_rd)
      else $error("shading memory read not answered");

endmodule
